// ### rtl/dpr_pkg.sv
// shared constants and types of the dual-port block RAM
// assumes one clock for both ports and a static configuration
package dpr_pkg;
    localparam int ROWS     = 512;   // physical rows of the storage array
    localparam int ROW_W    = 36;    // bits per row: four lanes of byte plus parity
    localparam int LANE_W   = 9;     // one lane: data byte and its parity bit
    localparam int LANES    = 4;     // lanes per row
    localparam int BYTE_W   = 8;     // data bits per lane
    localparam int ADDR_W   = 14;    // widest port address (16384 x 1)
    localparam int ROW_AW   = 9;     // row index width
    localparam int BE_W     = 4;     // byte enables, one per lane
    localparam int READ_LAT = 2;     // edges from request to registered read data

    localparam logic [ROW_W-1:0] ROW_ZERO = 36'h0_0000_0000;  // zero fill for the unused bits of read data

    typedef enum logic [1:0] {
        MODE_TDP,      // true dual port
        MODE_PDP,      // pseudo dual port: a writes, b reads
        MODE_SP,       // single port on a
        MODE_ROM       // preloaded, read only
    } dpr_mode_t;

    typedef enum logic [2:0] {
        WID_1, WID_2, WID_4, WID_9, WID_18, WID_36
    } dpr_width_t;

    typedef enum logic {
        ST_CONFIG,     // preload phase, user ports ignored
        ST_USER        // normal operation
    } dpr_state_t;

    typedef struct packed {
        logic              ce;     // port clock enable
        logic              we;     // write enable
        logic [BE_W-1:0]   be;     // byte enables, x18 uses [1:0]
        logic [ADDR_W-1:0] addr;   // word address at the port width
        logic [ROW_W-1:0]  din;    // write data, low bits used
    } dpr_req_t;

    typedef struct packed {
        logic             valid;   // one-cycle pulse with fresh read data
        logic [ROW_W-1:0] dout;    // read data, low bits used
    } dpr_rsp_t;

    typedef struct packed {
        logic              we;     // preload strobe
        logic [ROW_AW-1:0] row;    // row to preload
        logic [ROW_W-1:0]  data;   // full row contents
    } dpr_init_t;
endpackage : dpr_pkg

// ### rtl/dpr_block_ram.sv
// dual-port block RAM: 18 Kbit array, input and output registers per port
// assumes the configuration inputs are static while ST_USER is active
//
// Function
// - 18 Kbit array, per-port registers and enables
// - true dual, pseudo dual, single port, ROM
// - optional parity bit stored per byte
// - byte enables honoured at x18 and x36
// - each port picks its own width
// - bits laid out contiguously word by word
// - same layout seen from every port width
// - contents preloaded before user operation
// - ROM: write controls kept disabled
`timescale 1ns/1ps
module dpr_block_ram
    import dpr_pkg::*;
(
    input  wire logic       CLK_I,         // shared clock of both ports
    input  wire logic       RESET_N_I,     // async reset, active low
    input  wire dpr_mode_t  MODE_I,        // memory mode
    input  wire logic       PARITY_EN_I,   // store parity bits when high
    input  wire dpr_width_t WIDTH_A_I,     // port a shape
    input  wire dpr_width_t WIDTH_B_I,     // port b shape
    input  wire dpr_init_t  INIT_I,        // preload row writes
    input  wire logic       CFG_DONE_I,    // ends the preload phase
    input  wire dpr_req_t   PORT_A_I,      // port a request
    input  wire dpr_req_t   PORT_B_I,      // port b request
    output dpr_rsp_t        PORT_A_O,      // port a read data
    output dpr_rsp_t        PORT_B_O,      // port b read data
    output logic            CFG_ERR_O,     // illegal shape for the mode
    output logic            USER_ACTIVE_O  // preload over, ports live
);

    // row holding the addressed word for a given port width
    function automatic logic [ROW_AW-1:0] row_of(input dpr_width_t w,
                                                 input logic [ADDR_W-1:0] a);
        case (w)
            WID_1:   row_of = a[13:5];
            WID_2:   row_of = a[12:4];
            WID_4:   row_of = a[11:3];
            WID_9:   row_of = a[10:2];
            WID_18:  row_of = a[9:1];
            default: row_of = a[8:0];
        endcase
    endfunction : row_of

    // first data bit of a narrow word inside the row's 32 data bits
    function automatic int narrow_off(input dpr_width_t w, input logic [ADDR_W-1:0] a);
        case (w)
            WID_1:   narrow_off = int'(a[4:0]);
            WID_2:   narrow_off = int'(a[3:0]) * 2;
            default: narrow_off = int'(a[2:0]) * 4;
        endcase
    endfunction : narrow_off

    function automatic int narrow_w(input dpr_width_t w);
        case (w)
            WID_1:   narrow_w = 1;
            WID_2:   narrow_w = 2;
            default: narrow_w = 4;
        endcase
    endfunction : narrow_w

    // merge a port write into a row; data bit d lives at lane d/8, bit d%8
    function automatic logic [ROW_W-1:0] wr_row(input logic [ROW_W-1:0] old,
                                                input dpr_width_t w,
                                                input logic [ADDR_W-1:0] a,
                                                input logic [ROW_W-1:0] din,
                                                input logic [BE_W-1:0] be,
                                                input logic par);
        logic [ROW_W-1:0] r;
        int               off;
        int               nw;
        int               d;
        int               s;
        logic             sel;
        r   = old;
        off = narrow_off(w, a);
        nw  = narrow_w(w);
        for (int l = 0; l < LANES; l++) begin
            for (int b = 0; b < LANE_W; b++) begin
                d   = l * BYTE_W + b;
                sel = 1'b0;
                s   = 0;
                case (w)
                    WID_9: begin
                        sel = (l == int'(a[1:0]));
                    end
                    WID_18: begin
                        sel = ((l / 2) == int'(a[0])) && be[l % 2];
                        s   = l % 2;
                    end
                    WID_36: begin
                        sel = be[l];
                        s   = l;
                    end
                    default: begin
                        if (b < BYTE_W && d >= off && d < off + nw) begin
                            r[l*LANE_W+b] = din[d-off];
                        end
                    end
                endcase
                if (sel) begin
                    // parity kept at zero when disabled
                    r[l*LANE_W+b] = (b == BYTE_W) ? (par & din[s*LANE_W+b]) : din[s*LANE_W+b];
                end
            end
        end
        wr_row = r;
    endfunction : wr_row

    // pick the addressed word out of a row, low-aligned
    function automatic logic [ROW_W-1:0] rd_row(input logic [ROW_W-1:0] row,
                                                input dpr_width_t w,
                                                input logic [ADDR_W-1:0] a);
        logic [ROW_W-1:0] o;
        int               d;
        o = ROW_ZERO;
        case (w)
            WID_9:  o[8:0]  = row[int'(a[1:0])*LANE_W +: LANE_W];
            WID_18: o[17:0] = row[int'(a[0])*2*LANE_W +: 2*LANE_W];
            WID_36: o       = row;
            default: begin
                for (int k = 0; k < 4; k++) begin
                    d = narrow_off(w, a) + k;
                    if (k < narrow_w(w)) begin
                        o[k] = row[(d/BYTE_W)*LANE_W + d%BYTE_W];
                    end
                end
            end
        endcase
        rd_row = o;
    endfunction : rd_row

    dpr_state_t       state;
    dpr_req_t         req_q [2];     // input registers
    dpr_width_t       wid   [2];
    logic             shape_ok [2];
    logic             may_wr   [2];
    logic             may_rd   [2];
    logic             wr_go    [2];
    logic             rd_go    [2];
    logic [ROW_AW-1:0] row_q   [2];
    logic [ROW_W-1:0] mem [ROWS];    // storage, no reset on purpose
    logic [ROW_W-1:0] next_row_b;
    logic [ROW_W-1:0] next_row_a;
    dpr_rsp_t         rsp_q [2];

    // preload phase ends once, user ports live afterwards
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state <= ST_CONFIG;
        end else begin
            case (state)
                ST_CONFIG: if (CFG_DONE_I) state <= ST_USER;
                ST_USER:   state <= ST_USER;
                default:   state <= ST_CONFIG;
            endcase
        end
    end

    // per-port permissions from the mode
    always_comb begin
        wid[0]      = WIDTH_A_I;
        wid[1]      = WIDTH_B_I;
        shape_ok[0] = !(MODE_I == MODE_TDP && WIDTH_A_I == WID_36);
        shape_ok[1] = !(MODE_I == MODE_TDP && WIDTH_B_I == WID_36);
        may_wr[0]   = (MODE_I == MODE_TDP) || (MODE_I == MODE_PDP) || (MODE_I == MODE_SP);
        may_rd[0]   = (MODE_I != MODE_PDP);
        may_wr[1]   = (MODE_I == MODE_TDP);
        may_rd[1]   = (MODE_I != MODE_SP);
        for (int p = 0; p < 2; p++) begin
            wr_go[p] = req_q[p].ce && req_q[p].we && may_wr[p] && shape_ok[p];
            rd_go[p] = req_q[p].ce && !req_q[p].we && may_rd[p] && shape_ok[p];
            row_q[p] = row_of(wid[p], req_q[p].addr);
        end
    end

    // input registers; ports are ignored during preload
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            req_q[0] <= '0;
            req_q[1] <= '0;
        end else begin
            req_q[0] <= PORT_A_I;
            req_q[1] <= PORT_B_I;
            if (state != ST_USER) begin
                req_q[0].ce <= 1'b0;
                req_q[1].ce <= 1'b0;
            end
        end
    end

    // b merged first so a same-row write from a keeps b's untouched bits
    always_comb begin
        next_row_b = wr_row(mem[row_q[1]], wid[1], req_q[1].addr, req_q[1].din,
                            req_q[1].be, PARITY_EN_I);
        next_row_a = wr_row((wr_go[1] && row_q[1] == row_q[0]) ? next_row_b : mem[row_q[0]],
                            wid[0], req_q[0].addr, req_q[0].din, req_q[0].be, PARITY_EN_I);
    end

    // array writes: preload rows, then user writes; a wins on overlap
    always_ff @(posedge CLK_I) begin
        if (state == ST_CONFIG && INIT_I.we) begin
            mem[INIT_I.row] <= INIT_I.data;
        end
        if (state == ST_USER) begin
            if (wr_go[1]) mem[row_q[1]] <= next_row_b;
            if (wr_go[0]) mem[row_q[0]] <= next_row_a;
        end
    end

    // output registers; a read sees the row before a same-edge write
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rsp_q[0] <= '0;
            rsp_q[1] <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                rsp_q[p].valid <= rd_go[p];
                if (rd_go[p]) rsp_q[p].dout <= rd_row(mem[row_q[p]], wid[p], req_q[p].addr);
            end
        end
    end

    assign PORT_A_O      = rsp_q[0];
    assign PORT_B_O      = rsp_q[1];
    assign CFG_ERR_O     = !shape_ok[0] || !shape_ok[1];
    assign USER_ACTIVE_O = (state == ST_USER);

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    // typed formal so the member selects resolve in every front end
    sequence rd_req_s(dpr_req_t p);
        p.ce && !p.we && USER_ACTIVE_O && MODE_I == MODE_TDP && !CFG_ERR_O;
    endsequence

    rom_no_write_a: assert property (MODE_I == MODE_ROM |-> !wr_go[0] && !wr_go[1])
        else $error("write performed in ROM mode");
    cfg_no_user_a: assert property (state == ST_CONFIG |=> !rsp_q[0].valid)
        else $error("read answered during preload");
    rd_lat_a_a: assert property (rd_req_s(PORT_A_I) ##1 MODE_I == MODE_TDP
                                 |-> ##1 PORT_A_O.valid)
        else $error("port a read data late");
    wr_quiet_a: assert property (PORT_A_I.ce && PORT_A_I.we |-> ##2 !PORT_A_O.valid)
        else $error("write produced read data");
    pdp_b_ro_a: assert property (MODE_I == MODE_PDP |-> !wr_go[1] && !rd_go[0])
        else $error("pseudo dual port direction broken");
    tdp_no36_a: assert property (MODE_I == MODE_TDP && WIDTH_A_I == WID_36
                                 |-> CFG_ERR_O && !wr_go[0])
        else $error("x36 accepted in true dual port");
    be_none_a: assert property (wr_go[0] && !wr_go[1] && WIDTH_A_I == WID_36
                                && req_q[0].be == 4'h0 && $stable(WIDTH_A_I)
                                |=> mem[$past(row_q[0])] == $past(mem[row_q[0]]))
        else $error("disabled bytes were written");
    par_off_a: assert property (wr_go[0] && !wr_go[1] && !PARITY_EN_I
                                && WIDTH_A_I == WID_36 && req_q[0].be == 4'hf
                                |=> mem[$past(row_q[0])][8] == 1'b0)
        else $error("parity stored while disabled");
    sp_b_off_a: assert property (MODE_I == MODE_SP ##1 MODE_I == MODE_SP
                                 |-> !PORT_B_O.valid)
        else $error("port b answered in single port mode");

endmodule : dpr_block_ram

// ### verification/dpr_fabric_model.sv
// fabric model: preloads a few rows, then ends the preload phase
// assumes the bench owns reset; drives on the falling clock edge
`timescale 1ns/1ps
module dpr_fabric_model
    import dpr_pkg::*;
#(
    parameter int PRELOAD_ROWS = 4         // rows written while preloading
)(
    input  wire logic CLK_I,               // shared clock
    input  wire logic RESET_N_I,           // async reset, active low
    output dpr_init_t INIT_O,              // preload row writes
    output logic      CFG_DONE_O           // ends preload phase
);
    int row;

    // walk restarts on each reset, like a fresh configuration
    always @(negedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            row <= 0;
            INIT_O <= '0;
            CFG_DONE_O <= 1'b0;
        end else if (row < PRELOAD_ROWS) begin
            INIT_O <= '{we: 1'b1, row: 9'(row), data: {4'(row), 16'hc0de, 16'(row)}};
            row <= row + 1;
        end else begin
            INIT_O <= '0;          // strobe dropped before user traffic starts
            CFG_DONE_O <= 1'b1;
        end
    end
endmodule : dpr_fabric_model

// ### verification/dual_port_block_ram_bench.sv
// bench for the block RAM: one task per scenario, self-checking
// assumes the fabric model preloads rows 0..3 after every reset
`timescale 1ns/1ps
module dual_port_block_ram_bench;
    import dpr_pkg::*;
    logic       clk;
    logic       reset_n;
    dpr_mode_t  mode;
    dpr_width_t wid_a;
    dpr_width_t wid_b;
    logic       par_en;
    dpr_init_t  init;
    logic       cfg_done;
    dpr_req_t   req_a;
    dpr_req_t   req_b;
    dpr_rsp_t   rsp_a;
    dpr_rsp_t   rsp_b;
    dpr_req_t   req_hi_a;
    dpr_req_t   req_hi_b;
    dpr_rsp_t   rsp_hi_b;
    logic       cfg_err;
    logic       user_active;
    int         n_fail = 0;
    int         cmp_count = 0;

    dpr_block_ram u_dpr_block_ram (.CLK_I(clk), .RESET_N_I(reset_n), .MODE_I(mode),
        .PARITY_EN_I(par_en), .WIDTH_A_I(wid_a), .WIDTH_B_I(wid_b), .INIT_I(init),
        .CFG_DONE_I(cfg_done), .PORT_A_I(req_a), .PORT_B_I(req_b), .PORT_A_O(rsp_a),
        .PORT_B_O(rsp_b), .CFG_ERR_O(cfg_err), .USER_ACTIVE_O(user_active));
    dpr_fabric_model u_dpr_fabric_model (.CLK_I(clk), .RESET_N_I(reset_n),
        .INIT_O(init), .CFG_DONE_O(cfg_done));
    // second block for the cascade scenario, fed the same preload stream
    dpr_block_ram u_dpr_block_ram_hi (.CLK_I(clk), .RESET_N_I(reset_n), .MODE_I(mode),
        .PARITY_EN_I(par_en), .WIDTH_A_I(wid_a), .WIDTH_B_I(wid_b), .INIT_I(init),
        .CFG_DONE_I(cfg_done), .PORT_A_I(req_hi_a), .PORT_B_I(req_hi_b), .PORT_A_O(),
        .PORT_B_O(rsp_hi_b), .CFG_ERR_O(), .USER_ACTIVE_O());

    // 100 MHz clock
    always #5 clk = ~clk;

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // reset with a new static shape, wait for the ports to go live
    task automatic cfg(input dpr_mode_t m, input dpr_width_t wa, input dpr_width_t wb,
                       input logic par);
        int n;
        @(negedge clk);
        reset_n = 1'b0;
        mode = m;
        wid_a = wa;
        wid_b = wb;
        par_en = par;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        n = 0;
        while (user_active !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check({35'h0, user_active}, 36'h1);
    endtask : cfg

    // one request for one cycle; a one-cycle gap keeps strobes distinct
    task automatic op(input bit pb, input logic we, input logic [3:0] be,
                      input logic [13:0] addr, input logic [35:0] din, input logic ce = 1'b1);
        dpr_req_t r;
        r = '{ce: ce, we: we, be: be, addr: addr, din: din};
        @(negedge clk);
        if (pb) req_b = r;
        else req_a = r;
        @(negedge clk);
        if (pb) req_b = '0;
        else req_a = '0;
    endtask : op

    // answer stands for the one cycle after the edge that follows the request edge
    task automatic rd(input bit pb, input logic [13:0] addr, input logic [35:0] mask,
                      input logic [35:0] exp, input logic expv = 1'b1);
        dpr_rsp_t r;
        op(pb, 1'b0, 4'h0, addr, 36'h0);
        @(negedge clk); // valid is gone after the next rising edge
        r = pb ? rsp_b : rsp_a;
        check({35'h0, r.valid}, {35'h0, expv});
        if (expv) check(r.dout & mask, exp);
    endtask : rd

    task automatic rom_case;
        cfg(MODE_ROM, WID_36, WID_36, 1'b1);
        for (int r = 0; r < 4; r++) rd(0, 14'(r), '1, {4'(r), 16'hc0de, 16'(r)});
        op(0, 1'b1, 4'hf, 14'h1, 36'h0);
        rd(0, 14'h1, '1, {4'h1, 16'hc0de, 16'h1});
    endtask : rom_case

    task automatic pdp_case;
        logic [35:0] d;
        d = 36'h9_a5c3_1e7b;
        cfg(MODE_PDP, WID_36, WID_9, 1'b1);
        check({35'h0, cfg_err}, 36'h0);
        op(0, 1'b1, 4'hf, 14'h2, d);
        op(0, 1'b1, 4'hf, 14'h2, 36'h0, 1'b0);
        for (int l = 0; l < 4; l++) rd(1, 14'(8 + l), 36'h1ff, 36'(d[9*l +: 9]));
        op(0, 1'b1, 4'h2, 14'h2, 36'h0);
        op(0, 1'b1, 4'h0, 14'h2, '1); // no byte enabled, row must stay
        op(1, 1'b1, 4'hf, 14'h8, 36'h0);
        rd(1, 14'h9, 36'h1ff, 36'h0);
        rd(1, 14'ha, 36'h1ff, 36'(d[18 +: 9]));
        rd(1, 14'h8, 36'h1ff, 36'(d[8:0]));
    endtask : pdp_case

    // parity disabled at both the lane path and the full row path
    task automatic par_off_case;
        cfg(MODE_PDP, WID_9, WID_36, 1'b0);
        for (int l = 0; l < 4; l++) begin
            op(0, 1'b1, 4'h0, 14'(12 + l), {27'h0, 1'b1, 8'(8'h3c + l)});
        end
        rd(1, 14'h3, '1, {9'h03f, 9'h03e, 9'h03d, 9'h03c});
        cfg(MODE_PDP, WID_36, WID_9, 1'b0);
        op(0, 1'b1, 4'hf, 14'h5, '1);
        rd(1, 14'h14, 36'h1ff, 36'h0ff);
    endtask : par_off_case

    task automatic tdp_case;
        logic [15:0] v;
        v = 16'hb4e1;
        cfg(MODE_TDP, WID_1, WID_18, 1'b1);
        check({35'h0, cfg_err}, 36'h0);
        op(1, 1'b1, 4'h3, 14'hc, 36'h3ffff);
        for (int d = 0; d < 16; d++) op(0, 1'b1, 4'h0, 14'(192 + d), {35'h0, v[d]});
        rd(1, 14'hc, 36'h3ffff, {18'h0, 1'b1, v[15:8], 1'b1, v[7:0]});
        rd(0, 14'(195), 36'h1, {35'h0, v[3]});
        @(negedge clk);
        wid_a = WID_36;
        #1;
        check({35'h0, cfg_err}, 36'h1);
    endtask : tdp_case

    task automatic sp_case;
        cfg(MODE_SP, WID_18, WID_18, 1'b1);
        op(0, 1'b1, 4'h3, 14'he, 36'h2_5a3c);
        rd(0, 14'he, 36'h3ffff, 36'h2_5a3c);
        rd(1, 14'he, 36'h3ffff, 36'h0, 1'b0);
    endtask : sp_case

    // x4 write seen through x2 words: bits 4..7 of row 9
    task automatic narrow_case;
        cfg(MODE_TDP, WID_4, WID_2, 1'b1);
        op(0, 1'b1, 4'h0, 14'(73), 36'ha);
        rd(1, 14'(146), 36'h3, 36'h2);
        rd(1, 14'(147), 36'h3, 36'h2);
    endtask : narrow_case

    // fifo built out here: pointers live in the bench, the block only stores
    task automatic fifo_case;
        int wp;
        int rp;
        wp = 0;
        rp = 0;
        cfg(MODE_PDP, WID_18, WID_18, 1'b1);
        for (int k = 0; k < 3; k++) begin
            op(0, 1'b1, 4'h3, 14'(wp), 36'(18'h1_0a00 + k));
            wp++;
        end
        while (rp != wp) begin
            rd(1, 14'(rp), 36'h3ffff, 36'(18'h1_0a00 + rp));
            rp++;
        end
    endtask : fifo_case

    // two blocks and an outside decoder on address bit 9 form 1024 x 36
    task automatic cascade_case;
        dpr_req_t   r;
        logic [9:0] ga;
        cfg(MODE_PDP, WID_36, WID_36, 1'b1);
        for (int k = 0; k < 2; k++) begin
            ga = 10'(16 + 512 * k);
            r = '{ce: 1'b1, we: 1'b1, be: 4'hf, addr: {5'h0, ga[8:0]},
                  din: {32'h5a5a_0000, 4'(k)}};
            @(negedge clk);
            if (ga[9]) req_hi_a = r;
            else req_a = r;
            @(negedge clk);
            req_a = '0;
            req_hi_a = '0;
        end
        for (int k = 0; k < 2; k++) begin
            ga = 10'(16 + 512 * k);
            r = '{ce: 1'b1, we: 1'b0, be: 4'h0, addr: {5'h0, ga[8:0]}, din: 36'h0};
            @(negedge clk);
            req_b = r;
            req_hi_b = r;
            @(negedge clk);
            req_b = '0;
            req_hi_b = '0;
            @(negedge clk);
            check(ga[9] ? rsp_hi_b.dout : rsp_b.dout, {32'h5a5a_0000, 4'(k)});
        end
    endtask : cascade_case

    // hang guard, far beyond the few hundred cycles the scenarios need
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        mode = MODE_TDP;
        wid_a = WID_36;
        wid_b = WID_36;
        par_en = 1'b1;
        req_a = '0;
        req_b = '0;
        req_hi_a = '0;
        req_hi_b = '0;
        rom_case();
        pdp_case();
        par_off_case();
        tdp_case();
        sp_case();
        narrow_case();
        fifo_case();
        cascade_case();
        print_verdict();
    end
endmodule : dual_port_block_ram_bench
